//--- include/lpm_pkg.sv
// constants, register map and state types of the low power mode controller
// assumes a 50 MHz system clock and a 32-bit AXI4-Lite register port
package lpm_pkg;
    // register indices; the byte address is four times the index
    localparam logic [5:0] CPU_CTL_IDX = 6'h1f;
    localparam logic [5:0] IO_CTL_IDX = 6'h3f;
    localparam logic [5:0] IRQ_EN_IDX = 6'h21;
    localparam logic [5:0] STATUS_IDX = 6'h20;
    // field positions
    localparam int CPU_UNDIV_BIT = 7;
    localparam int CPU_STBY_BIT = 6;
    localparam int CPU_GRANT_BIT = 5;
    localparam int CPU_QUICK_BIT = 3;
    localparam int IO_HALT_BIT = 5;
    // values after reset
    localparam logic [7:0] CPU_CTL_RST = 8'h00;
    localparam logic IO_HALT_RST = 1'b0;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;
    localparam logic [5:0] SYNC_RST = 6'h1f;
    // restart delays in tenths of a clock, as characterised
    localparam int SLEEP_EXIT_TENTHS = 15;
    localparam int IDLE_EXIT_TENTHS = 95;
    localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_TENTHS + 9) / 10;
    localparam int IDLE_EXIT_CYC = (IDLE_EXIT_TENTHS + 9) / 10;
    // extra bus grant latency in idle, and oscillator stabilisation
    localparam int BUS_EXTRA_CYC = 8;
    localparam int STANDBY_STAB_CYC = 131072;
    localparam int QUICK_STAB_CYC = 64;
    localparam int CNT_W = 18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_RUN, ST_SLEEP, ST_SYSSTOP, ST_IDLE, ST_STANDBY,
        ST_RESUME, ST_STAB, ST_BUSWAIT, ST_GRANT
    } lpm_state_e;

    typedef enum logic [1:0] {
        CAUSE_RST, CAUSE_NMI, CAUSE_IRQ, CAUSE_BUS
    } lpm_cause_e;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_CPU, SEL_IO, SEL_IRQ, SEL_STAT
    } lpm_sel_e;
endpackage

//--- verilog/lpm_ctrl.sv
// low power mode controller: sleep, system stop, idle, standby, quick standby
// assumes the cpu core pulses the sleep instruction on ref_clk and that the
// reset, nmi, irq and bus request pins are asynchronous to ref_clk
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - io halt bit set stops serial, clocked serial and timer blocks.
// - clearing io halt bit restarts the halted peripherals.
// - io halt plus sleep with bits 6 and 3 clear stops cpu and peripherals, clock pin runs.
// - system stop wakes like sleep but not from halted peripherals.
// - sleep exit resumes about 1.5 clocks after wake condition.
// - bits 6 and 3 clear: sleep or system stop per io halt.
// - bit 3 only plus io halt: idle, oscillator output blocked.
// - idle halts refresh and peripherals, external irqs still accepted.
// - idle exits on reset low, nmi or enabled external irq.
// - nmi or enabled irq with flag set: service, return after sleep.
// - enabled irq with flag clear: skip service, continue after sleep.
// - idle exit resumes about 9.5 clocks after wake condition.
// - idle with grant enable grants bus 8 clocks later than normal.
// - bus request released in idle: block clock, stay idle.
// - bit 6 only plus io halt: standby, 131072 cycle restart.
// - both bits plus io halt: quick standby, 64 cycle restart.
// - waking irq dropping before stabilisation returns to standby.
// - standby bus request granted only after stabilisation timer.
// - bit 7 zero halves crystal clock, one passes it undivided.
module lpm_ctrl #(
    parameter int ADDR_W = 8,
    parameter int STANDBY_CYC = lpm_pkg::STANDBY_STAB_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu core side
    input wire logic sleep_instruction,
    input wire logic interrupt_enable_flag,
    input wire logic periph_irq,
    // external pins, active low except the bus request
    input wire logic reset_pin_n,
    input wire logic nmi_n,
    input wire logic external_irq_zero_n,
    input wire logic external_irq_one_n,
    input wire logic external_irq_two_n,
    input wire logic external_bus_request,
    // power and clock controls
    output logic cpu_halt,
    output logic periph_halt,
    output logic refresh_halt,
    output logic osc_enable,
    output logic system_clock_output_en,
    output logic crystal_undivided,
    output logic bus_grant,
    // restart signalling to the core
    output logic resume,
    output logic service_irq,
    output logic skip_service
);
    import lpm_pkg::*;

    function automatic lpm_sel_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [5:0] idx;
        idx = a[7:2];
        if (a[1:0] != 2'h0) reg_sel = SEL_NONE;
        else if (idx == CPU_CTL_IDX) reg_sel = SEL_CPU;
        else if (idx == IO_CTL_IDX) reg_sel = SEL_IO;
        else if (idx == IRQ_EN_IDX) reg_sel = SEL_IRQ;
        else if (idx == STATUS_IDX) reg_sel = SEL_STAT;
        else reg_sel = SEL_NONE;
    endfunction

    // pin synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else begin
            sync1_q <= {external_bus_request, external_irq_two_n,
                        external_irq_one_n, external_irq_zero_n,
                        nmi_n, reset_pin_n};
            sync2_q <= sync1_q;
        end
    end

    // registers
    logic [7:0] cpu_ctl_q;
    logic io_halt_q;
    logic [2:0] irq_en_q;
    lpm_state_e state_q, state_d;
    lpm_state_e back_q, back_d;
    lpm_cause_e cause_q, cause_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // axi write channel
    logic aw_have_q, w_have_q, bvalid_q, awready_q, wready_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q;
    wire aw_take = s_axi_awvalid & awready_q;
    wire w_take = s_axi_wvalid & wready_q;
    wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
    wire b_done = bvalid_q & s_axi_bready;
    wire lpm_sel_e wsel = reg_sel(awaddr_q);
    wire wr_ok = wr_go & (wsel != SEL_NONE);
    wire aw_have_d = (aw_have_q | aw_take) & ~wr_go;
    wire w_have_d = (w_have_q | w_take) & ~wr_go;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= ~aw_have_d;
            wready_q <= ~w_have_d;
            if (aw_take) awaddr_q <= s_axi_awaddr;
            if (w_take) wdata_q <= s_axi_wdata;
            if (w_take) wstrb0_q <= s_axi_wstrb[0];
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (b_done) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    wire wr_byte = wr_ok & wstrb0_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_ctl_q <= CPU_CTL_RST;
            io_halt_q <= IO_HALT_RST;
            irq_en_q <= IRQ_EN_RST;
        end else if (wr_byte) begin
            if (wsel == SEL_CPU) cpu_ctl_q <= wdata_q[7:0];
            if (wsel == SEL_IO) io_halt_q <= wdata_q[IO_HALT_BIT];
            if (wsel == SEL_IRQ) irq_en_q <= wdata_q[2:0];
        end
    end

    // axi read channel
    logic arready_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire ar_take = s_axi_arvalid & arready_q;
    wire lpm_sel_e rsel = reg_sel(s_axi_araddr);
    wire [31:0] rd_mux =
        (rsel == SEL_CPU) ? {24'h0, cpu_ctl_q} :
        (rsel == SEL_IO) ? {24'h0, 2'h0, io_halt_q, 5'h0} :
        (rsel == SEL_IRQ) ? {29'h0, irq_en_q} :
        (rsel == SEL_STAT) ? {26'h0, cause_q, state_q} : 32'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_q & s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // wake sources
    wire rst_act = ~sync2_q[0];
    wire nmi_act = ~sync2_q[1];
    wire irq_act = |(~sync2_q[4:2] & irq_en_q);
    wire bus_req = sync2_q[5];
    wire grant_en = cpu_ctl_q[CPU_GRANT_BIT];
    wire quick = cpu_ctl_q[CPU_QUICK_BIT];
    wire ext_wake = rst_act | nmi_act | irq_act;
    wire sleep_wake = ext_wake | periph_irq;
    wire bus_go = grant_en & bus_req & ~ext_wake;
    wire lpm_cause_e ext_cause = rst_act ? CAUSE_RST :
                                 nmi_act ? CAUSE_NMI : CAUSE_IRQ;
    wire [CNT_W-1:0] stab_load = quick ? CNT_W'(QUICK_STAB_CYC - 1)
                                       : CNT_W'(STANDBY_CYC - 1);
    wire lpm_state_e sleep_target =
        ~io_halt_q ? ST_SLEEP :
        (cpu_ctl_q[CPU_STBY_BIT] ? ST_STANDBY :
         (quick ? ST_IDLE : ST_SYSSTOP));
    wire stab_drop = (cause_q == CAUSE_IRQ) ? ~irq_act :
                     (cause_q == CAUSE_BUS) ? ~bus_req : 1'b0;

    always_comb begin
        state_d = state_q;
        back_d = back_q;
        cause_d = cause_q;
        cnt_d = (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
        case (state_q)
            ST_RUN: begin
                if (sleep_instruction) state_d = sleep_target;
            end
            ST_SLEEP, ST_SYSSTOP: begin
                // halted peripherals cannot wake system stop
                if (ext_wake | (periph_irq & state_q == ST_SLEEP)) begin
                    state_d = ST_RESUME;
                    cause_d = ext_wake ? ext_cause : CAUSE_IRQ;
                    cnt_d = CNT_W'(SLEEP_EXIT_CYC - 1);
                end
            end
            ST_IDLE: begin
                back_d = ST_IDLE;
                if (ext_wake) begin
                    state_d = ST_RESUME;
                    cause_d = ext_cause;
                    cnt_d = CNT_W'(IDLE_EXIT_CYC - 1);
                end else if (bus_go) begin
                    state_d = ST_BUSWAIT;
                    cause_d = CAUSE_BUS;
                    cnt_d = CNT_W'(BUS_EXTRA_CYC);
                end
            end
            ST_STANDBY: begin
                back_d = ST_STANDBY;
                if (ext_wake | bus_go) begin
                    state_d = ST_STAB;
                    cause_d = ext_wake ? ext_cause : CAUSE_BUS;
                    cnt_d = stab_load;
                end
            end
            ST_STAB: begin
                if (stab_drop) state_d = ST_STANDBY;
                else if (cnt_q == '0) begin
                    if (cause_q == CAUSE_BUS) state_d = ST_GRANT;
                    else state_d = ST_RUN;
                end
            end
            ST_BUSWAIT: begin
                if (~bus_req) state_d = ST_IDLE;
                else if (cnt_q == '0) state_d = ST_GRANT;
            end
            ST_GRANT: begin
                if (~bus_req) state_d = back_q;
            end
            ST_RESUME: begin
                if (cnt_q == '0) state_d = ST_RUN;
            end
            default: state_d = ST_RUN;
        endcase
    end

    wire leaving = (state_q == ST_RESUME || state_q == ST_STAB) &&
                   state_d == ST_RUN;
    wire do_irq = (cause_q == CAUSE_NMI) ||
                  (cause_q == CAUSE_IRQ && interrupt_enable_flag);
    wire st_low = state_d != ST_RUN;
    wire st_dark = state_d == ST_IDLE || state_d == ST_STANDBY ||
                   state_d == ST_STAB || state_d == ST_BUSWAIT;
    wire st_osc_off = state_d == ST_STANDBY || state_d == ST_STAB;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_RUN;
            back_q <= ST_IDLE;
            cause_q <= CAUSE_RST;
            cnt_q <= '0;
            cpu_halt <= 1'b0;
            periph_halt <= 1'b0;
            refresh_halt <= 1'b0;
            osc_enable <= 1'b1;
            system_clock_output_en <= 1'b1;
            crystal_undivided <= 1'b0;
            bus_grant <= 1'b0;
            resume <= 1'b0;
            service_irq <= 1'b0;
            skip_service <= 1'b0;
        end else begin
            state_q <= state_d;
            back_q <= back_d;
            cause_q <= cause_d;
            cnt_q <= cnt_d;
            cpu_halt <= st_low;
            periph_halt <= io_halt_q | st_dark;
            refresh_halt <= st_dark;
            osc_enable <= ~st_osc_off;
            system_clock_output_en <= ~st_dark;
            crystal_undivided <= cpu_ctl_q[CPU_UNDIV_BIT];
            bus_grant <= state_d == ST_GRANT;
            resume <= leaving;
            service_irq <= leaving & do_irq;
            skip_service <= leaving & (cause_q == CAUSE_IRQ) &
                            ~interrupt_enable_flag;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_halt_io;
        io_halt_q |=> periph_halt;
    endproperty
    a_halt_io: assert property (p_halt_io) else $error("io halt ignored");

    property p_release_io;
        !io_halt_q && state_d == ST_RUN |=> !periph_halt;
    endproperty
    a_release_io: assert property (p_release_io)
        else $error("peripherals not restarted");

    property p_sysstop;
        state_q == ST_SYSSTOP |-> cpu_halt && periph_halt &&
            system_clock_output_en;
    endproperty
    a_sysstop: assert property (p_sysstop) else $error("bad system stop");

    property p_sysstop_periph;
        state_q == ST_SYSSTOP && !ext_wake |=> state_q == ST_SYSSTOP;
    endproperty
    a_sysstop_periph: assert property (p_sysstop_periph)
        else $error("system stop left without external wake");

    property p_sleep_exit;
        state_q == ST_SLEEP && sleep_wake |-> !resume [*3] ##1 resume;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("sleep restart timing wrong");

    property p_sleep_entry;
        state_q == ST_RUN && sleep_instruction && !io_halt_q
            |=> state_q == ST_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("plain sleep not entered");

    property p_idle_dark;
        state_q == ST_IDLE |-> osc_enable && !system_clock_output_en &&
            refresh_halt && periph_halt;
    endproperty
    a_idle_dark: assert property (p_idle_dark) else $error("idle clocks");

    property p_idle_exit;
        state_q == ST_IDLE && ext_wake |-> ##11 resume;
    endproperty
    a_idle_exit: assert property (p_idle_exit)
        else $error("idle restart timing wrong");

    property p_idle_grant;
        state_q == ST_IDLE && bus_go ##1 bus_req [*8] ##1 bus_req
            |-> !bus_grant ##1 bus_grant;
    endproperty
    a_idle_grant: assert property (p_idle_grant)
        else $error("idle bus grant timing wrong");

    property p_grant_release;
        state_q == ST_GRANT && !bus_req |=> !bus_grant &&
            state_q == back_q;
    endproperty
    a_grant_release: assert property (p_grant_release)
        else $error("bus release not handled");

    property p_stab_drop;
        state_q == ST_STAB && cause_q == CAUSE_IRQ && !irq_act
            |=> state_q == ST_STANDBY && !osc_enable;
    endproperty
    a_stab_drop: assert property (p_stab_drop)
        else $error("dropped irq left standby");

    property p_quick_stab;
        state_q == ST_STANDBY && quick && ext_wake && !$past(rst)
            ##1 !stab_drop [*8] |-> !resume;
    endproperty
    a_quick_stab: assert property (p_quick_stab)
        else $error("quick standby restarted too early");

    property p_service;
        leaving && cause_q == CAUSE_NMI |=> service_irq && !skip_service;
    endproperty
    a_service: assert property (p_service) else $error("nmi not served");

    property p_skip;
        leaving && cause_q == CAUSE_IRQ && !interrupt_enable_flag
            |=> skip_service && !service_irq;
    endproperty
    a_skip: assert property (p_skip) else $error("service not skipped");

    c_sleep_resume: cover property (state_q == ST_SLEEP ##[1:5] resume);
    c_idle_grant: cover property (state_q == ST_BUSWAIT ##[1:12] bus_grant);
    c_standby_drop: cover property (state_q == ST_STAB ##1
        state_q == ST_STANDBY);
endmodule

//--- dv/lpm_ext_model.sv
// far side model: nmi, reset pin, three irq pins and an external bus master
// assumes the bench commands one event at a time on ref_clk
`timescale 1ns/1ps
module lpm_ext_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // command: kind 0 nmi, 1..3 irq, 4 bus request, 5 reset pin
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [17:0] hold,
    // pins
    output logic reset_pin_n,
    output logic nmi_n,
    output logic [2:0] irq_n,
    output logic bus_req
);
    logic [17:0] cnt_q;
    logic [2:0] kind_q;
    logic act;

    // a request stands exactly hold cycles, then returns to its pull level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 18'h0;
            kind_q <= 3'h0;
        end else if (go) begin
            cnt_q <= hold;
            kind_q <= kind;
        end else if (cnt_q != 18'h0) begin
            cnt_q <= cnt_q - 18'h1;
        end
    end
    assign act = cnt_q != 18'h0;
    assign nmi_n = !(act && kind_q == 3'h0);
    assign irq_n[0] = !(act && kind_q == 3'h1);
    assign irq_n[1] = !(act && kind_q == 3'h2);
    assign irq_n[2] = !(act && kind_q == 3'h3);
    assign bus_req = act && kind_q == 3'h4;
    assign reset_pin_n = !(act && kind_q == 3'h5);
endmodule

//--- dv/low_power_mode_controller_tb.sv
// self-checking bench of the low power mode controller, int register model
// assumes lpm_ext_model as far side and a shortened standby count
`timescale 1ns/1ps
module low_power_mode_controller_tb;
    import lpm_pkg::*;
    localparam int STBY = 100;
    localparam logic [7:0] CPU_A = {CPU_CTL_IDX, 2'b00};
    localparam logic [7:0] IO_A = {IO_CTL_IDX, 2'b00};
    localparam logic [7:0] IRQ_A = {IRQ_EN_IDX, 2'b00};
    localparam logic [7:0] STAT_A = {STATUS_IDX, 2'b00};
    logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic sleep_in, ie_flag, periph_irq, rpin_n, nmi_n, breq, ext_go;
    logic [2:0] irq_n, ext_kind;
    logic [17:0] ext_hold;
    logic cpu_halt, periph_halt, refresh_halt, osc_en, clk_en, undiv, grant;
    logic resume, svc, skp;
    int error_cnt = 0;
    int tests_run = 0;
    int m_cpu, m_io, m_ien;

    lpm_ctrl #(.ADDR_W(8), .STANDBY_CYC(STBY)) uut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_instruction(sleep_in), .interrupt_enable_flag(ie_flag),
        .periph_irq(periph_irq), .reset_pin_n(rpin_n), .nmi_n(nmi_n),
        .external_irq_zero_n(irq_n[0]), .external_irq_one_n(irq_n[1]),
        .external_irq_two_n(irq_n[2]), .external_bus_request(breq),
        .cpu_halt(cpu_halt), .periph_halt(periph_halt),
        .refresh_halt(refresh_halt), .osc_enable(osc_en),
        .system_clock_output_en(clk_en), .crystal_undivided(undiv),
        .bus_grant(grant), .resume(resume), .service_irq(svc),
        .skip_service(skp)
    );
    lpm_ext_model ext (
        .ref_clk(ref_clk), .rst(rst), .go(ext_go), .kind(ext_kind),
        .hold(ext_hold), .reset_pin_n(rpin_n), .nmi_n(nmi_n),
        .irq_n(irq_n), .bus_req(breq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // mode chosen by the sleep instruction, as status state code
    function automatic int exp_state(input logic [7:0] c, input logic h);
        if (!h) return 1;
        if (c[6]) return 4;
        return c[3] ? 3 : 2;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1) begin
            @(posedge ref_clk);
            if (!aw && awready) aw = 1;
            if (!w && wready) w = 1;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic setmode(input logic [7:0] c, input logic h,
                           input logic [2:0] ien);
        logic [1:0] r;
        m_cpu = c;
        m_io = h ? 32'h20 : 0;
        m_ien = ien;
        wr(CPU_A, c, r);
        wr(IO_A, m_io, r);
        wr(IRQ_A, ien, r);
    endtask

    task automatic status(input int s);
        logic [31:0] d;
        logic [1:0] r;
        rd(STAT_A, d, r);
        check(d[3:0], s);
    endtask

    // waits for any earlier pin request to expire before sleeping
    task automatic sleep_now();
        repeat (160) @(posedge ref_clk);
        sleep_in <= 1'b1;
        @(posedge ref_clk);
        sleep_in <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic wake(input logic [2:0] k, input int hold, output int lat);
        ext_kind <= k;
        ext_hold <= hold[17:0];
        ext_go <= 1'b1;
        @(posedge ref_clk);
        ext_go <= 1'b0;
        lat = 0;
        while (resume !== 1'b1 && grant !== 1'b1 && lat < 300) begin
            @(posedge ref_clk);
            lat++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        int lat, base, e, s;
        logic [31:0] d, seed;
        logic [1:0] r;
        logic [7:0] c;
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 48'h0;
        {sleep_in, ie_flag, periph_irq, ext_go} = 4'h4;
        ext_kind = 3'h0;
        ext_hold = 18'h0;
        seed = 32'h58ba7699;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(CPU_A, d, r);
        check(d, CPU_CTL_RST);
        check(undiv, 0);
        check({osc_en, clk_en, cpu_halt, periph_halt}, 4'hc);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(CPU_A, seed, r);
            rd(CPU_A, d, r);
            check(d, seed[7:0]);
            check(undiv, seed[7]);
            wr(IO_A, seed, r);
            check(periph_halt, seed[5]);
            check(cpu_halt, 0);
            wr(IRQ_A, seed, r);
            rd(IRQ_A, d, r);
            check(d, seed[2:0]);
        end
        wr(8'h10, seed, r);
        check(r, RESP_SLVERR);
        rd(8'h10, d, r);
        check(r, RESP_SLVERR);
        check(d, 32'h0);
        for (int m = 0; m < 8; m++) begin
            c = {1'b0, m[1], 2'b00, m[0], 3'b000};
            setmode(c, m[2], 3'h7);
            s = exp_state(c, m[2]);
            sleep_now();
            status(s);
            check(clk_en, s < 3);
            check(refresh_halt, s > 2);
            check(periph_halt, m[2]);
            check(osc_en, s != 4);
            check(cpu_halt, 1);
            wake(3'h0, 150, lat);
            if (m == 0) base = lat;
            e = s == 3 ? IDLE_EXIT_CYC : SLEEP_EXIT_CYC;
            if (s == 4) e = m[0] ? QUICK_STAB_CYC : STBY;
            check(lat - base, e - SLEEP_EXIT_CYC);
            check(svc, 1);
        end
        setmode(8'h00, 1'b1, 3'h5);
        sleep_now();
        periph_irq <= 1'b1;
        repeat (20) @(posedge ref_clk);
        status(2);
        periph_irq <= 1'b0;
        wake(3'h2, 20, lat);
        check(lat, 300);
        ie_flag <= 1'b0;
        wake(3'h1, 20, lat);
        check({svc, skp, resume}, 3'h3);
        ie_flag <= 1'b1;
        setmode(8'h00, 1'b0, 3'h7);
        sleep_now();
        periph_irq <= 1'b1;
        wake(3'h7, 0, lat);
        check(svc, 1);
        periph_irq <= 1'b0;
        setmode(8'h40, 1'b1, 3'h7);
        sleep_now();
        wake(3'h3, 30, lat);
        check(lat, 300);
        status(4);
        wake(3'h0, 150, lat);
        check(svc, 1);
        setmode(8'h28, 1'b1, 3'h7);
        sleep_now();
        wake(3'h4, 40, lat);
        check(lat - base, BUS_EXTRA_CYC + 1 - SLEEP_EXIT_CYC);
        repeat (60) @(posedge ref_clk);
        check({grant, clk_en}, 2'h0);
        status(3);
        wake(3'h5, 150, lat);
        check({svc, skp, resume}, 3'h1);
        setmode(8'h68, 1'b1, 3'h7);
        sleep_now();
        wake(3'h4, 150, lat);
        check(lat - base, QUICK_STAB_CYC - SLEEP_EXIT_CYC);
        repeat (200) @(posedge ref_clk);
        status(4);
        wake(3'h0, 150, lat);
        check(resume, 1);
        stop_test();
    end
endmodule
